// ### verilog/bcps_map.svh
`ifndef BCPS_MAP_SVH
`define BCPS_MAP_SVH

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define BCPS_OFF_ASSIGN 8'h0A
`define BCPS_OFF_SLOW 8'h0B
`define BCPS_OFF_DATA 8'h0C
`define BCPS_OFF_DIR 8'h0D
`define BCPS_OFF_STAT 8'h0E

// ****************************************
// Port assignment register fields
// ****************************************
`define BCPS_B_BUS_EN_DIS 7
`define BCPS_B_CG_TEST 6
`define BCPS_B_QT_OE 5
`define BCPS_B_INV_SEL 4
`define BCPS_B_STRB_EN 3
`define BCPS_B_RW_EN 2
`define BCPS_B_TRIM_EN 1
`define BCPS_ASSIGN_MASK 8'hFE

// ****************************************
// Reset values
// ****************************************
`define BCPS_ASSIGN_RST 8'h80
`define BCPS_SLOW_RST 8'h00

// ****************************************
// Pin slots inside the five-pin vectors
// ****************************************
`define BCPS_S7 4
`define BCPS_S6 3
`define BCPS_S5 2
`define BCPS_SSTRB 1
`define BCPS_SRW 0

// ****************************************
// Timing: bus clock phase of last quarter
// ****************************************
`define BCPS_LAST_QTR 2'h3

`endif

// ### verilog/bcps_pkg.sv
package bcps_pkg;

  // ****************************************
  // Access sequencer and bit-7 pin selection
  // ****************************************
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_ACC} bcps_state_e;
  typedef enum logic [1:0] {
    SEL7_GPIO, SEL7_BUSEN, SEL7_BCLKN, SEL7_TRIM
  } bcps_sel7_e;

  // ****************************************
  // Divider state
  // ****************************************
  typedef struct packed {
    logic [1:0] phase;
    logic [8:0] slow_cnt;
    logic slow_clk;
  } bcps_gen_s;

  // ****************************************
  // Main block state
  // ****************************************
  typedef struct packed {
    logic captured;
    logic [1:0] mode;
    logic [7:0] asgn;
    logic [7:0] slow_div;
    logic [4:0] gp_data;
    logic [4:0] gp_dir;
    bcps_state_e state;
    logic [1:0] cyc_left;
    logic stretched;
    logic acc_read;
    logic acc_a0;
    logic acc_byte;
    logic done;
    logic [7:0] rdata;
    logic bclk;
    logic [4:0] pin_out;
    logic [4:0] pin_oe_n;
    logic pullup7;
    logic pulldn;
  } bcps_main_s;

endpackage

// ### verilog/bcps_tick_if.sv
`timescale 1ns/1ps
// Bus clock phase and slow divider, shared between divider and top
interface bcps_tick_if;
  logic [1:0] phase;
  logic slow_clk;
  logic [7:0] slow_div;
  modport gen (input slow_div, output phase, output slow_clk);
  modport usr (output slow_div, input phase, input slow_clk);
endinterface

// ### verilog/bcps_sync.sv
`timescale 1ns/1ps
// Two-flop synchroniser; no reset so reset-time pin levels pass through
module bcps_sync #(
  parameter int WIDTH = 5
) (
  clk,
  d,
  q
);
  input wire logic clk;
  input wire logic [WIDTH-1:0] d;
  output logic [WIDTH-1:0] q;

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] q_reg;

  // First stage feeds only the second stage
  always_ff @(posedge clk) begin
    meta_reg <= d;
    q_reg <= meta_reg;
  end

  assign q = q_reg;
endmodule // bcps_sync

// ### verilog/bcps_clkgen.sv
`timescale 1ns/1ps
// Bus clock phase counter and slow-mode divider.
// The crystal rate is clk/2, so one bus clock is four clk cycles.
module bcps_clkgen import bcps_pkg::*; (
  input wire logic clk,
  input wire logic resetn,
  bcps_tick_if.gen tick
);
  `include "bcps_map.svh"

  bcps_gen_s gen_reg, gen_next;

  // Phase advance and divider reload
  always_comb begin
    gen_next = gen_reg;
    gen_next.phase = gen_reg.phase + 2'h1;
    if (gen_reg.slow_cnt == 9'h000) begin
      gen_next.slow_clk = ~gen_reg.slow_clk;
      // Equal half periods keep the duty even for any setting
      if (tick.slow_div == 8'h00) begin
        gen_next.slow_cnt = 9'h000;
      end else begin
        gen_next.slow_cnt = {tick.slow_div, 1'b0} - 9'h001;
      end
    end else begin
      gen_next.slow_cnt = gen_reg.slow_cnt - 9'h001;
    end
  end

  // State register
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      gen_reg <= '0;
    end else begin
      gen_reg <= gen_next;
    end
  end

  assign tick.phase = gen_reg.phase;
  assign tick.slow_clk = gen_reg.slow_clk;

  // ****************************************
  // Checks
  // ****************************************
  slow_xtal_a: assert property (
    @(posedge clk) disable iff (!resetn)
    // The first edge after release still shows the reset level
    ($past(resetn) && tick.slow_div == 8'h00
     && $past(tick.slow_div) == 8'h00
     && $past(gen_reg.slow_cnt) == 9'h000)
    |-> gen_reg.slow_clk != $past(gen_reg.slow_clk))
    else $error("slow clock not at crystal rate");
endmodule // bcps_clkgen

// ### verilog/bcps_top.sv
// Decided for this implementation: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
// Function
// - enable low only in bus clock high
// - stretched: enable only in last quarter
// - disable bit governs; on after expanded reset
// - single-chip bit7 pull-up during and after reset
// - selected bit7 carries inverted bus clock
// - trim enable puts slow clock on bit7
// - slow clock crystal rate when divider zero, always even duty
// - bus enable overrides slow clock output
// - clearing trim enable stops slow clock on bit7
// - test enable puts test clocks on bit6
// - test clocks only while tracking output off
// - strobe active low, xnor of a0, size
// - read/write shows direction in expanded modes
// - mode from pins at reset, then reused
// - bus clock runs at half crystal
// - read/write inactive until its enable set
// - strobe inactive until its enable set
module bcps_top import bcps_pkg::*; (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic acc_req,
  input wire logic acc_read,
  input wire logic acc_addr0,
  input wire logic byte_size_access,
  input wire logic [1:0] acc_stretch,
  output logic acc_done,
  input wire logic queue_track_0,
  input wire logic queue_track_1,
  input wire logic clockgen_test_in,
  output logic bus_clock_out,
  input wire logic port_e_bit7_in,
  output logic port_e_bit7_out,
  output logic port_e_bit7_oe_n,
  output logic port_e_bit7_pullup,
  input wire logic port_e_bit6_in,
  output logic port_e_bit6_out,
  output logic port_e_bit6_oe_n,
  input wire logic port_e_bit5_in,
  output logic port_e_bit5_out,
  output logic port_e_bit5_oe_n,
  output logic mode_pulldown,
  input wire logic low_byte_strobe_in,
  output logic low_byte_strobe_n,
  output logic low_byte_strobe_oe_n,
  input wire logic rw_in,
  output logic rw_out,
  output logic rw_oe_n
);
  `include "bcps_map.svh"

  // ****************************************
  // Helpers
  // ****************************************

  function automatic bcps_sel7_e sel7(input logic [7:0] a);
    if (!a[`BCPS_B_BUS_EN_DIS]) begin
      if (a[`BCPS_B_INV_SEL]) begin
        return SEL7_BCLKN;
      end else begin
        return SEL7_BUSEN;
      end
    end else if (a[`BCPS_B_TRIM_EN]) begin
      return SEL7_TRIM;
    end else begin
      return SEL7_GPIO;
    end
  endfunction

  // Pin slots to register byte layout
  function automatic logic [7:0] to_byte(input logic [4:0] s);
    return {s[`BCPS_S7], s[`BCPS_S6], s[`BCPS_S5], 1'b0,
            s[`BCPS_SSTRB], s[`BCPS_SRW], 2'h0};
  endfunction

  // Register byte layout to pin slots
  function automatic logic [4:0] to_slots(input logic [7:0] b);
    return {b[7], b[6], b[5], b[3], b[2]};
  endfunction

  // ****************************************
  // Submodules
  // ****************************************
  bcps_main_s st_reg, st_next;
  logic [4:0] pin_sync;
  bcps_sel7_e sel_cur;
  bcps_tick_if tick();

  assign tick.slow_div = st_reg.slow_div;
  assign sel_cur = sel7(st_reg.asgn);

  bcps_clkgen u_clkgen (
    .clk(clk),
    .resetn(resetn),
    .tick(tick)
  );

  // Pin levels come from outside the clock domain
  bcps_sync #(.WIDTH(5)) u_sync (
    .clk(clk),
    .d({port_e_bit7_in, port_e_bit6_in, port_e_bit5_in,
        low_byte_strobe_in, rw_in}),
    .q(pin_sync)
  );

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb begin
    logic [1:0] ph_n;
    logic bus_en_low;
    logic exp_n;
    ph_n = tick.phase + 2'h1;
    bus_en_low = 1'b0;
    exp_n = 1'b0;
    st_next = st_reg;
    st_next.done = 1'b0;
    st_next.rdata = 8'h00;

    if (!st_reg.captured) begin
      st_next.captured = 1'b1;
      st_next.mode = {pin_sync[`BCPS_S6], pin_sync[`BCPS_S5]};
      st_next.asgn[`BCPS_B_BUS_EN_DIS] = ~pin_sync[`BCPS_S5];
    end

    // Register writes; unmapped offsets are ignored
    if (reg_wr) begin
      if (reg_addr == `BCPS_OFF_ASSIGN) begin
        st_next.asgn = reg_wdata & `BCPS_ASSIGN_MASK;
      end else if (reg_addr == `BCPS_OFF_SLOW) begin
        st_next.slow_div = reg_wdata;
      end else if (reg_addr == `BCPS_OFF_DATA) begin
        st_next.gp_data = to_slots(reg_wdata);
      end else if (reg_addr == `BCPS_OFF_DIR) begin
        st_next.gp_dir = to_slots(reg_wdata);
      end
    end

    // Register reads; unmapped offsets read zero
    if (reg_rd) begin
      if (reg_addr == `BCPS_OFF_ASSIGN) begin
        st_next.rdata = st_reg.asgn;
      end else if (reg_addr == `BCPS_OFF_SLOW) begin
        st_next.rdata = st_reg.slow_div;
      end else if (reg_addr == `BCPS_OFF_DATA) begin
        st_next.rdata = to_byte((st_reg.gp_data & st_reg.gp_dir)
                                | (pin_sync & ~st_reg.gp_dir));
      end else if (reg_addr == `BCPS_OFF_DIR) begin
        st_next.rdata = to_byte(st_reg.gp_dir);
      end else if (reg_addr == `BCPS_OFF_STAT) begin
        st_next.rdata = {st_reg.mode, sel_cur, tick.slow_clk,
                         st_reg.state != ST_IDLE, 2'h0};
      end
    end

    // Access sequencer; requests while busy are dropped
    case (st_reg.state)
      ST_IDLE: begin
        if (acc_req) begin
          st_next.state = ST_WAIT;
          st_next.cyc_left = acc_stretch;
          st_next.stretched = |acc_stretch;
          st_next.acc_read = acc_read;
          st_next.acc_a0 = acc_addr0;
          st_next.acc_byte = byte_size_access;
        end
      end
      ST_WAIT: begin
        // Start on a bus clock boundary
        if (tick.phase == `BCPS_LAST_QTR) begin
          st_next.state = ST_ACC;
        end
      end
      ST_ACC: begin
        if (tick.phase == `BCPS_LAST_QTR) begin
          if (st_reg.cyc_left == 2'h0) begin
            st_next.state = ST_IDLE;
            st_next.done = 1'b1;
          end else begin
            st_next.cyc_left = st_reg.cyc_left - 2'h1;
          end
        end
      end
      default: begin
        st_next.state = ST_IDLE;
      end
    endcase

    st_next.bclk = ph_n[1];

    bus_en_low = ph_n[1];
    if (st_next.state == ST_ACC && st_next.stretched) begin
      bus_en_low = (st_next.cyc_left == 2'h0)
                   && (ph_n == `BCPS_LAST_QTR);
    end

    st_next.pin_out = st_reg.gp_data;
    st_next.pin_oe_n = ~st_reg.gp_dir;

    case (sel_cur)
      SEL7_BUSEN: begin
        st_next.pin_out[`BCPS_S7] = ~bus_en_low;
        st_next.pin_oe_n[`BCPS_S7] = 1'b0;
      end
      SEL7_BCLKN: begin
        st_next.pin_out[`BCPS_S7] = ~ph_n[1];
        st_next.pin_oe_n[`BCPS_S7] = 1'b0;
      end
      SEL7_TRIM: begin
        st_next.pin_out[`BCPS_S7] = tick.slow_clk;
        st_next.pin_oe_n[`BCPS_S7] = 1'b0;
      end
      default: begin
      end
    endcase

    if (st_reg.asgn[`BCPS_B_QT_OE]) begin
      st_next.pin_out[`BCPS_S6] = queue_track_1;
      st_next.pin_oe_n[`BCPS_S6] = 1'b0;
      st_next.pin_out[`BCPS_S5] = queue_track_0;
      st_next.pin_oe_n[`BCPS_S5] = 1'b0;
    end else if (st_reg.asgn[`BCPS_B_CG_TEST]) begin
      st_next.pin_out[`BCPS_S6] = clockgen_test_in;
      st_next.pin_oe_n[`BCPS_S6] = 1'b0;
    end

    exp_n = st_next.mode[0];
    if (exp_n && st_reg.asgn[`BCPS_B_STRB_EN]) begin
      st_next.pin_out[`BCPS_SSTRB] = ~(st_next.acc_a0 ^ st_next.acc_byte);
      st_next.pin_oe_n[`BCPS_SSTRB] = 1'b0;
    end
    if (exp_n && st_reg.asgn[`BCPS_B_RW_EN]) begin
      st_next.pin_out[`BCPS_SRW] = (st_next.state != ST_ACC)
                                   || st_next.acc_read;
      st_next.pin_oe_n[`BCPS_SRW] = 1'b0;
    end

    st_next.pullup7 = ~exp_n & st_next.pin_oe_n[`BCPS_S7];
    // Mode pin pull-downs only while in reset
    st_next.pulldn = 1'b0;
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_reg <= '0;
      st_reg.asgn <= `BCPS_ASSIGN_RST;
      st_reg.slow_div <= `BCPS_SLOW_RST;
      st_reg.pin_oe_n <= 5'h1F;
      st_reg.pullup7 <= 1'b1;
      st_reg.pulldn <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from the state register
  assign reg_rdata = st_reg.rdata;
  assign acc_done = st_reg.done;
  assign bus_clock_out = st_reg.bclk;
  assign port_e_bit7_out = st_reg.pin_out[`BCPS_S7];
  assign port_e_bit7_oe_n = st_reg.pin_oe_n[`BCPS_S7];
  assign port_e_bit7_pullup = st_reg.pullup7;
  assign port_e_bit6_out = st_reg.pin_out[`BCPS_S6];
  assign port_e_bit6_oe_n = st_reg.pin_oe_n[`BCPS_S6];
  assign port_e_bit5_out = st_reg.pin_out[`BCPS_S5];
  assign port_e_bit5_oe_n = st_reg.pin_oe_n[`BCPS_S5];
  assign mode_pulldown = st_reg.pulldn;
  assign low_byte_strobe_n = st_reg.pin_out[`BCPS_SSTRB];
  assign low_byte_strobe_oe_n = st_reg.pin_oe_n[`BCPS_SSTRB];
  assign rw_out = st_reg.pin_out[`BCPS_SRW];
  assign rw_oe_n = st_reg.pin_oe_n[`BCPS_SRW];

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  en_high_phase_a: assert property (
    ($past(sel_cur) == SEL7_BUSEN && !port_e_bit7_out) |-> bus_clock_out)
    else $error("bus enable low outside high phase");

  en_stretch_a: assert property (
    ($past(sel_cur) == SEL7_BUSEN && !port_e_bit7_out
     && st_reg.state == ST_ACC && st_reg.stretched)
    |-> st_reg.cyc_left == 2'h0 && tick.phase == `BCPS_LAST_QTR)
    else $error("stretched enable outside last quarter");

  en_reset_a: assert property (
    ($rose(st_reg.captured) && st_reg.mode[0])
    |-> !st_reg.asgn[`BCPS_B_BUS_EN_DIS])
    else $error("bus enable off after expanded reset");

  pullup_sc_a: assert property (
    (!st_reg.mode[0] && port_e_bit7_oe_n) |-> port_e_bit7_pullup)
    else $error("single-chip pull-up missing");

  inv_clock_a: assert property (
    $past(sel_cur) == SEL7_BCLKN
    |-> port_e_bit7_out == !bus_clock_out && !port_e_bit7_oe_n)
    else $error("bit7 not inverted bus clock");

  trim_out_a: assert property (
    $past(sel_cur) == SEL7_TRIM
    |-> port_e_bit7_out == $past(tick.slow_clk))
    else $error("bit7 not slow clock");

  en_override_a: assert property (
    (!st_reg.asgn[`BCPS_B_BUS_EN_DIS] && !st_reg.asgn[`BCPS_B_INV_SEL]
     && st_reg.asgn[`BCPS_B_TRIM_EN]) ##1 !bus_clock_out
    |-> port_e_bit7_out)
    else $error("slow clock leaked past bus enable");

  test_clock_a: assert property (
    (st_reg.asgn[`BCPS_B_CG_TEST] && !st_reg.asgn[`BCPS_B_QT_OE])
    |=> port_e_bit6_out == $past(clockgen_test_in) && !port_e_bit6_oe_n)
    else $error("test clock not on bit6");

  strobe_xnor_a: assert property (
    (st_reg.mode[0] && st_reg.asgn[`BCPS_B_STRB_EN] && $stable(st_reg.mode))
    |=> low_byte_strobe_n == !(st_reg.acc_a0 ^ st_reg.acc_byte))
    else $error("strobe not xnor");

  rw_off_a: assert property (
    !(st_reg.mode[0] && st_reg.asgn[`BCPS_B_RW_EN]) && $stable(st_reg.mode)
    |=> rw_oe_n == !$past(st_reg.gp_dir[`BCPS_SRW]))
    else $error("direction pin active while disabled");

  bus_half_a: assert property (
    $past(resetn, 2) |-> bus_clock_out == !$past(bus_clock_out, 2))
    else $error("bus clock not half crystal");

  stretch_c: cover property (
    st_reg.state == ST_ACC && st_reg.stretched && !port_e_bit7_out);
  inv_sel_c: cover property ($past(sel_cur) == SEL7_BCLKN);
  trim_sel_c: cover property ($past(sel_cur) == SEL7_TRIM);
  done_c: cover property (acc_done);
endmodule // bcps_top

// ### sim/bcps_ext_model.sv
`timescale 1ns/1ps
// Far side: board straps and pull-ups, plus a bus device that latches
// the multiplexed address and gates its own data drive
module bcps_ext_model (
  input wire logic clk,
  input wire logic strap_a,
  input wire logic strap_b,
  input wire logic bclk,
  input wire logic [4:0] pin_out,
  input wire logic [4:0] pin_oe_n,
  input wire logic pullup7,
  output logic [4:0] pin_in,
  output logic ext_drive,
  output logic [3:0] latch_cnt
);
  logic wobble = 1'b0;
  // A floating bit7 wanders, so a stale level never passes for real
  always @(posedge clk) begin
    wobble <= ~wobble;
  end
  // Pin levels: strap resistors on mode pins, pull-ups on strobe and rw
  always_comb begin
    pin_in[4] = !pin_oe_n[4] ? pin_out[4] : (pullup7 ? 1'b1 : wobble);
    pin_in[3] = !pin_oe_n[3] ? pin_out[3] : strap_b;
    pin_in[2] = !pin_oe_n[2] ? pin_out[2] : strap_a;
    pin_in[1] = !pin_oe_n[1] ? pin_out[1] : 1'b1;
    pin_in[0] = !pin_oe_n[0] ? pin_out[0] : 1'b1;
  end
  // gated data drive
  // Device drives data only on reads while the enable is low
  assign ext_drive = pin_in[0] && !pin_in[4] && bclk;
  // address latch
  // Rising edge of the inverted bus clock captures the address
  initial latch_cnt = 4'h0;
  always @(posedge pin_in[4]) begin
    latch_cnt <= latch_cnt + 4'h1;
  end
endmodule // bcps_ext_model

// ### sim/tb_bus_control_pin_select.sv
`timescale 1ns/1ps
`include "bcps_map.svh"
module tb_bus_control_pin_select;
  typedef struct packed {
    logic [7:0] asgn;
    logic [1:0] sel;
  } bcps_row_s;
  // Assignment value beside the bit7 function it should select
  localparam bcps_row_s ROWS [7] = '{
    '{8'h80, 2'h0}, '{8'h82, 2'h3}, '{8'h00, 2'h1}, '{8'h02, 2'h1},
    '{8'h10, 2'h2}, '{8'h90, 2'h0}, '{8'h92, 2'h3}
  };
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic acc_req = 1'b0;
  logic acc_read = 1'b0;
  logic acc_addr0 = 1'b0;
  logic byte_size_access = 1'b0;
  logic [1:0] acc_stretch = 2'h0;
  logic queue_track_0 = 1'b0;
  logic queue_track_1 = 1'b0;
  logic clockgen_test_in = 1'b0;
  logic strap_a = 1'b1;
  logic strap_b = 1'b0;
  logic acc_done, bus_clock_out, mode_pulldown, pullup7;
  logic [4:0] pin_in;
  wire [4:0] pin_out;
  wire [4:0] pin_oe_n;
  logic ext_drive;
  logic [3:0] latch_cnt;
  int err_total = 0;
  int n_checks = 0;

  always #12.5 clk = ~clk;

  bcps_top bcps_top_i (
    .clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .acc_req, .acc_read, .acc_addr0, .byte_size_access, .acc_stretch,
    .acc_done, .queue_track_0, .queue_track_1, .clockgen_test_in,
    .bus_clock_out, .mode_pulldown,
    .port_e_bit7_in(pin_in[4]), .port_e_bit7_out(pin_out[4]),
    .port_e_bit7_oe_n(pin_oe_n[4]), .port_e_bit7_pullup(pullup7),
    .port_e_bit6_in(pin_in[3]), .port_e_bit6_out(pin_out[3]),
    .port_e_bit6_oe_n(pin_oe_n[3]), .port_e_bit5_in(pin_in[2]),
    .port_e_bit5_out(pin_out[2]), .port_e_bit5_oe_n(pin_oe_n[2]),
    .low_byte_strobe_in(pin_in[1]), .low_byte_strobe_n(pin_out[1]),
    .low_byte_strobe_oe_n(pin_oe_n[1]), .rw_in(pin_in[0]),
    .rw_out(pin_out[0]), .rw_oe_n(pin_oe_n[0])
  );

  bcps_ext_model bcps_ext_model_i (
    .clk, .strap_a, .strap_b, .bclk(bus_clock_out), .pin_out, .pin_oe_n,
    .pullup7, .pin_in, .ext_drive, .latch_cnt
  );

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic cmp(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  // Straps stay on through reset so the synchroniser fills with them
  task automatic do_reset(input logic a, input logic b);
    @(posedge clk);
    resetn <= 1'b0;
    strap_a <= a;
    strap_b <= b;
    repeat (16) @(posedge clk);
    #1 cmp("pulls in reset", 8'h03, {6'h00, mode_pulldown, pullup7});
    @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    #1 cmp("pull-down after", 8'h00, {7'h00, mode_pulldown});
    $display("reset test done");
  endtask

  // Counts high samples and level changes of bus clock or bit7
  task automatic meas(input int n, input logic pick7, output int hi,
                      output int tg);
    logic prev;
    logic v;
    hi = 0;
    tg = 0;
    repeat (4) @(posedge clk);
    #1 prev = pick7 ? pin_out[4] : bus_clock_out;
    repeat (n) begin
      @(posedge clk);
      #1 v = pick7 ? pin_out[4] : bus_clock_out;
      hi += int'(v);
      tg += int'(v != prev);
      prev = v;
    end
  endtask

  // One access; counts enable-low and far-side drive cycles of the
  // access's own bus cycles, and enable-low cycles outside clock high
  task automatic access(input logic r, input logic a0, input logic sz,
                        input logic [1:0] st, output int lows,
                        output int bad, output int drv,
                        output logic [1:0] lv);
    int i;
    int k;
    int left;
    int at;
    logic lowv [64];
    logic drvv [64];
    lows = 0;
    bad = 0;
    drv = 0;
    left = -1;
    at = 0;
    @(posedge clk);
    acc_req <= 1'b1;
    acc_read <= r;
    acc_addr0 <= a0;
    byte_size_access <= sz;
    acc_stretch <= st;
    @(posedge clk);
    acc_req <= 1'b0;
    for (i = 0; i < 60 && left != 0; i++) begin
      @(posedge clk);
      #1 lowv[i] = !pin_oe_n[4] && !pin_out[4];
      drvv[i] = ext_drive;
      if (lowv[i] && !bus_clock_out) bad++;
      if (left > 0) left--;
      // Direction is read in the last access cycle, before idle
      if (acc_done === 1'b1) begin
        left = 2;
        at = i;
      end else if (left < 0) begin
        lv = {pin_out[0], pin_out[1]};
      end
    end
    if (left != 0) begin
      err_total++;
      $display("unexpected acc_done: expected 1 seen 0");
      end_of_test();
    end
    // The enable also pulses while waiting, so only the
    // (stretch+1) bus cycles that end at done are counted
    for (k = at + 1 - 4 * (int'(st) + 1); k <= at; k++) begin
      if (k >= 0 && lowv[k]) lows++;
      if (k >= 0 && drvv[k]) drv++;
    end
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    logic [7:0] d;
    int hi, tg, lows, bad, drv, i;
    logic [1:0] lv;
    logic [3:0] lc;
    do_reset(1'b1, 1'b0);
    rd(`BCPS_OFF_ASSIGN, d);
    cmp("assign expanded", 8'h00, d);
    rd(`BCPS_OFF_STAT, d);
    cmp("mode bits", 8'h01, {6'h00, d[7:6]});
    meas(16, 1'b0, hi, tg);
    cmp("bus clock highs", 8'h08, hi[7:0]);
    cmp("bus clock edges", 8'h08, tg[7:0]);
    wr(`BCPS_OFF_ASSIGN, 8'h0C);
    for (i = 0; i < 8; i++) begin
      access(i[2], i[1], i[0], 2'h0, lows, bad, drv, lv);
      cmp("rw strobe", {6'h00, i[2], ~(i[1] ^ i[0])}, {6'h00, lv});
      cmp("enable cycles", 8'h02, lows[7:0]);
      cmp("enable in low", 8'h00, bad[7:0]);
      cmp("read drive", {6'h00, i[2], 1'b0}, drv[7:0]);
    end
    for (i = 1; i < 4; i += 2) begin
      access(1'b1, 1'b0, 1'b0, i[1:0], lows, bad, drv, lv);
      cmp("stretch cycles", 8'h01, lows[7:0]);
      cmp("stretch in low", 8'h00, bad[7:0]);
      cmp("stretch drive", 8'h01, drv[7:0]);
    end
    wr(`BCPS_OFF_ASSIGN, 8'h00);
    access(1'b0, 1'b1, 1'b0, 2'h0, lows, bad, drv, lv);
    cmp("rw strobe off", 8'h03, {6'h00, pin_oe_n[1:0]});
    $display("access test done");
    for (i = 0; i < 7; i++) begin
      wr(`BCPS_OFF_ASSIGN, ROWS[i].asgn);
      rd(`BCPS_OFF_STAT, d);
      cmp("bit7 select", {6'h00, ROWS[i].sel}, {6'h00, d[5:4]});
    end
    $display("select table done");
    wr(`BCPS_OFF_ASSIGN, 8'h10);
    @(posedge clk);
    #1 lc = latch_cnt;
    for (i = 0; i < 16; i++) begin
      @(posedge clk);
      #1 cmp("inverted clock", {7'h00, ~bus_clock_out}, {7'h00, pin_out[4]});
    end
    cmp("address latches", 8'h04, {4'h0, latch_cnt - lc});
    wr(`BCPS_OFF_ASSIGN, 8'hC0);
    for (i = 0; i < 4; i++) begin
      if (i == 2) wr(`BCPS_OFF_ASSIGN, 8'hE0);
      @(posedge clk);
      clockgen_test_in <= i[0];
      queue_track_1 <= ~i[0];
      queue_track_0 <= i[0];
      repeat (4) @(posedge clk);
      #1 cmp("bit6 pin", {7'h00, (i < 2) ? i[0] : ~i[0]},
             {6'h00, pin_oe_n[3], pin_out[3]});
    end
    cmp("bit5 tracking", 8'h01, {6'h00, pin_oe_n[2], pin_out[2]});
    $display("test clock done");
    do_reset(1'b0, 1'b1);
    cmp("pull-up after", 8'h01, {7'h00, pullup7});
    rd(`BCPS_OFF_ASSIGN, d);
    cmp("assign single", 8'h80, d);
    rd(`BCPS_OFF_STAT, d);
    cmp("mode bits", 8'h02, {6'h00, d[7:6]});
    wr(`BCPS_OFF_ASSIGN, 8'h82);
    meas(16, 1'b1, hi, tg);
    cmp("slow highs", 8'h08, hi[7:0]);
    cmp("slow edges", 8'h10, tg[7:0]);
    wr(`BCPS_OFF_SLOW, 8'h02);
    meas(32, 1'b1, hi, tg);
    cmp("divided highs", 8'h10, hi[7:0]);
    cmp("divided edges", 8'h08, tg[7:0]);
    wr(`BCPS_OFF_ASSIGN, 8'h80);
    meas(8, 1'b1, hi, tg);
    cmp("slow stopped", 8'h01, {tg[6:0], pin_oe_n[4]});
    wr(`BCPS_OFF_DIR, 8'h80);
    for (i = 0; i < 2; i++) begin
      wr(`BCPS_OFF_DATA, {i[0], 7'h00});
      @(posedge clk);
      #1 cmp("bit7 port", {7'h00, i[0]}, {6'h00, pin_oe_n[4], pin_out[4]});
    end
    wr(8'h40, 8'hFF);
    rd(8'h40, d);
    cmp("unmapped read", 8'h00, d);
    rd(`BCPS_OFF_ASSIGN, d);
    cmp("assign kept", 8'h80, d);
    wr(`BCPS_OFF_ASSIGN, 8'hFF);
    rd(`BCPS_OFF_ASSIGN, d);
    cmp("assign mask", 8'hFE, d);
    $display("register test done");
    end_of_test();
  end
endmodule // tb_bus_control_pin_select
